// ### bench/epg_mac_sink.sv
`timescale 1ns/100ps
`default_nettype none
module epg_mac_sink (
	input wire logic clk_in,
	input wire logic stall_in,
	output logic ready_out
);
	int seed = 13392;
	// ready level, random stalls when asked
	initial begin
		ready_out = 1'b0;
		forever begin
			@(posedge clk_in);
			ready_out <= stall_in ? 1'($random(seed)) : 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### bench/test_eth_packet_client_generator.sv
`timescale 1ns/100ps
`default_nettype none
module test_eth_packet_client_generator;
	localparam logic [31:0] ID = 32'h1357_9BDF; // arbitrary value
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, lpbk = 0, stall = 0;
	logic [15:0] addr = 0;
	logic [31:0] wd = 0, rdata, sv;
	logic rdv, tv, rdy, sop, eop;
	logic [63:0] td;
	logic [2:0] te;
	logic [47:0] dst, src;
	logic [31:0] rq[$];
	int errors = 0, n_compared = 0, seed = 13392, sops = 0, bt = 0, i, k;
	logic [7:0] codes[5] = '{8'hD0, 8'h50, 8'h40, 8'h60, 8'h52};
	int nexp[5] = '{2, 2, 0, 0, 0};
	always #4 clk = ~clk;
	epg_packet_gen #(.CLIENT_ID(ID)) dut_u (.CLK_IN(clk), .RST_N_IN(rst_n),
		.REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wd),
		.REG_RDATA_OUT(rdata), .REG_RDVALID_OUT(rdv), .LOOPBACK_IN(lpbk),
		.TX_READY_IN(rdy), .TX_DATA_OUT(td), .TX_VALID_OUT(tv), .TX_SOP_OUT(sop),
		.TX_EOP_OUT(eop), .TX_EMPTY_OUT(te));
	epg_mac_sink sink_u (.clk_in(clk), .stall_in(stall), .ready_out(rdy));
	task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic wrt(logic [15:0] a, logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdc(logic [15:0] a, logic [31:0] e);
		rq.push_back(e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// read answers against oldest note
	always @(posedge clk) begin
		if (rdv === 1'b1) chk("rdata", rq.size() ? rq.pop_front() : 32'hDEAD_BEEF, rdata);
	end
	// accepted beats: header order, tail bytes, frame count
	always @(posedge clk) begin
		if (tv === 1'b1 && rdy === 1'b1) begin
			if (sop === 1'b1) begin
				sops++;
				bt = 0;
				chk("beat0", {dst, src[47:32]}, td);
			end else begin
				bt++;
				chk("payload", (bt == 1) ? {src[31:0], {4{8'h01}}} : {8{bt[7:0]}}, td);
			end
			if (eop === 1'b1) begin
				chk("empty", 3'h4, te);
				chk("beats", 64'h2, 64'(bt));
			end
		end
	end
	initial begin
		#100000;
		errors++;
		end_sim();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rdc(16'h1008, 32'h2580_0040);
		rdc(16'h1009, 32'h0000_000A);
		rdc(16'h1010, 32'h0000_0006);
		rdc(16'h1011, 32'h5678_0ADD);
		rdc(16'h1012, 32'h0000_1234);
		rdc(16'h1013, 32'h4321_0ADD);
		rdc(16'h1014, 32'h0000_8765);
		sv = $random(seed);
		wrt(16'h1000, sv);
		rdc(16'h1000, sv);
		wrt(16'h1001, ~ID);
		rdc(16'h1001, ID);
		rdc(16'h1FFF, 32'h0000_0000);
		rdc(16'h2000, 32'h0000_0000);
		wrt(16'h1008, 32'hFFFF_F814);
		rdc(16'h1008, 32'h3FFF_F814);
		@(posedge clk);
		lpbk <= 1'b1;
		rdc(16'h1010, 32'h0000_000E);
		lpbk <= 1'b0;
		$display("register test done");
		dst = 48'({$random(seed), $random(seed)});
		src = 48'({$random(seed), $random(seed)});
		wrt(16'h1011, dst[31:0]);
		wrt(16'h1012, {16'h0000, dst[47:32]});
		wrt(16'h1013, src[31:0]);
		wrt(16'h1014, {16'h0000, src[47:32]});
		wrt(16'h1009, 32'h0000_0002);
		stall <= 1'b1;
		for (k = 0; k < 5; k++) begin
			wrt(16'h1010, 32'h0000_0002);
			repeat (30) @(posedge clk);
			sops = 0;
			// apply the control code under test once the disable write has cleared the sent count
			wrt(16'h1010, {24'h00_0000, codes[k]});
			for (i = 0; i < 400 && sops < nexp[k]; i++) @(posedge clk);
			repeat (60) @(posedge clk);
			chk("frames", nexp[k], sops);
			$display("frame test %0d done", k);
		end
		// without count-stop the generator keeps going
		sops = 0;
		wrt(16'h1010, 32'h0000_0090);
		repeat (200) @(posedge clk);
		chk("freerun", 64'h1, 64'(sops > 2));
		// disable again; back-to-back kept so the gap choice stays put
		wrt(16'h1010, 32'h0000_0082);
		repeat (40) @(posedge clk);
		sops = 0;
		repeat (60) @(posedge clk);
		chk("stopped", 64'h0, 64'(sops));
		$display("free run test done");
		// mid-run reset brings registers back to defaults
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdc(16'h1009, 32'h0000_000A);
		rdc(16'h1000, 32'h0000_0000);
		rdc(16'h1010, 32'h0000_0006);
		repeat (2) @(posedge clk);
		$display("reset test done");
		end_sim();
	end
endmodule
`default_nettype wire

// ### inc/epg_map.svh
`ifndef EPG_MAP_SVH
`define EPG_MAP_SVH
`define EPG_WIN_LO 16'h1000
`define EPG_WIN_HI 16'h1FFF
`define EPG_OFF_SCRATCH 16'h1000
`define EPG_OFF_ID 16'h1001
`define EPG_OFF_SIZE 16'h1008
`define EPG_OFF_COUNT 16'h1009
`define EPG_OFF_CTRL 16'h1010
`define EPG_OFF_DAL 16'h1011
`define EPG_OFF_DAH 16'h1012
`define EPG_OFF_SAL 16'h1013
`define EPG_OFF_SAH 16'h1014
`define EPG_RST_SCRATCH 32'h0000_0000
`define EPG_RST_SIZE 30'h2580_0040
`define EPG_RST_COUNT 32'h0000_000A
`define EPG_RST_CTRL 8'h06
`define EPG_RST_DAL 32'h5678_0ADD
`define EPG_RST_DAH 16'h1234
`define EPG_RST_SAL 32'h4321_0ADD
`define EPG_RST_SAH 16'h8765
`define EPG_RST_LFSR 16'hACE1
`define EPG_CTRL_DIS 1
`define EPG_CTRL_LPBK 3
`define EPG_CTRL_PAT_HI 5
`define EPG_CTRL_PAT_LO 4
`define EPG_CTRL_CSTOP 6
`define EPG_CTRL_B2B 7
`define EPG_PAT_FIXED 2'h1
`define EPG_SIZE_MSB 10
`define EPG_MIN_LEN 11'h010
`endif

// ### inc/epg_pkg.sv
package epg_pkg;
	typedef enum logic [1:0] {S_IDLE, S_SEND, S_GAP} epg_state_e;
	typedef struct packed {
		logic [31:0] scratch;
		logic [29:0] size;
		logic [31:0] count;
		logic [7:0] ctrl;
		logic [31:0] dal;
		logic [15:0] dah;
		logic [31:0] sal;
		logic [15:0] sah;
		logic [31:0] rdata;
		logic rvalid;
		epg_state_e state;
		logic [7:0] beat;
		logic [31:0] sent;
		logic [15:0] lfsr;
		logic [3:0] gap;
		logic [63:0] data;
		logic valid;
		logic sop;
		logic eop;
		logic [2:0] empty;
	} epg_regs_s;
endpackage

// ### src/epg_packet_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "epg_map.svh"
module epg_packet_gen
	import epg_pkg::*;
#(
	parameter logic [31:0] CLIENT_ID = 32'h5046_4752 // arbitrary value
) (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic [15:0] REG_ADDR_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [31:0] REG_WDATA_IN,
	output logic [31:0] REG_RDATA_OUT,
	output logic REG_RDVALID_OUT,
	input wire logic LOOPBACK_IN,
	input wire logic TX_READY_IN,
	output logic [63:0] TX_DATA_OUT,
	output logic TX_VALID_OUT,
	output logic TX_SOP_OUT,
	output logic TX_EOP_OUT,
	output logic [2:0] TX_EMPTY_OUT
);
	localparam epg_regs_s RST_VAL = '{
		scratch: `EPG_RST_SCRATCH, size: `EPG_RST_SIZE, count: `EPG_RST_COUNT,
		ctrl: `EPG_RST_CTRL, dal: `EPG_RST_DAL, dah: `EPG_RST_DAH,
		sal: `EPG_RST_SAL, sah: `EPG_RST_SAH, rdata: 32'h0000_0000,
		rvalid: 1'b0, state: S_IDLE, beat: 8'h00, sent: 32'h0000_0000,
		lfsr: `EPG_RST_LFSR, gap: 4'h0, data: 64'h0000_0000_0000_0000,
		valid: 1'b0, sop: 1'b0, eop: 1'b0, empty: 3'h0};

	epg_regs_s r_reg;
	epg_regs_s r_next;
	logic [10:0] len;
	logic [7:0] last_beat;
	logic run;
	logic advance;

	// register read decode
	function automatic logic [31:0] reg_read(input epg_regs_s s, input logic [15:0] a,
			input logic lpbk);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			`EPG_OFF_SCRATCH: v = s.scratch;
			`EPG_OFF_ID: v = CLIENT_ID;
			`EPG_OFF_SIZE: v = {2'b00, s.size};
			`EPG_OFF_COUNT: v = s.count;
			`EPG_OFF_CTRL: begin
				v = {24'h00_0000, s.ctrl};
				v[`EPG_CTRL_LPBK] = lpbk;
				v[0] = 1'b0;
			end
			`EPG_OFF_DAL: v = s.dal;
			`EPG_OFF_DAH: v = {16'h0000, s.dah};
			`EPG_OFF_SAL: v = s.sal;
			`EPG_OFF_SAH: v = {16'h0000, s.sah};
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// frame length, short sizes padded to two beats
	// length from low size bits
	assign len = (r_reg.size[`EPG_SIZE_MSB:0] < `EPG_MIN_LEN) ? `EPG_MIN_LEN :
		r_reg.size[`EPG_SIZE_MSB:0];
	// widened by one bit so a 2047-byte frame does not wrap to zero beats
	assign last_beat = 8'(({1'b0, len} + 12'd7) >> 3) - 8'd1;
	// run only when enabled, fixed mode, count not reached if count-stop is set
	assign run = !r_reg.ctrl[`EPG_CTRL_DIS] &&
		(r_reg.ctrl[`EPG_CTRL_PAT_HI:`EPG_CTRL_PAT_LO] == `EPG_PAT_FIXED) &&
		!(r_reg.ctrl[`EPG_CTRL_CSTOP] && (r_reg.sent >= r_reg.count));
	assign advance = !r_reg.valid || TX_READY_IN;

	// next-state logic for registers and transmitter
	always_comb begin
		r_next = r_reg;
		r_next.rvalid = 1'b0;
		r_next.lfsr = {r_reg.lfsr[14:0], r_reg.lfsr[15] ^ r_reg.lfsr[13] ^
			r_reg.lfsr[12] ^ r_reg.lfsr[10]};
		if (advance) begin
			r_next.valid = 1'b0;
			r_next.sop = 1'b0;
			r_next.eop = 1'b0;
			r_next.empty = 3'h0;
			unique case (r_reg.state)
				S_IDLE: begin
					if (run) begin
						r_next.data = {r_reg.dah, r_reg.dal, r_reg.sah};
						r_next.valid = 1'b1;
						r_next.sop = 1'b1;
						r_next.beat = 8'h01;
						r_next.state = S_SEND;
					end
				end
				S_SEND: begin
					// source low half leads the second beat
					if (r_reg.beat == 8'h01) begin
						r_next.data = {r_reg.sal, {4{r_reg.beat}}};
					end else begin
						r_next.data = {8{r_reg.beat}};
					end
					r_next.valid = 1'b1;
					r_next.beat = r_reg.beat + 8'h01;
					if (r_reg.beat == last_beat) begin
						r_next.eop = 1'b1;
						r_next.empty = 3'(4'h8 - {1'b0, len[2:0]});
						r_next.sent = r_reg.sent + 32'h0000_0001;
						if (r_reg.ctrl[`EPG_CTRL_B2B]) begin
							r_next.state = S_IDLE;
						end else begin
							r_next.gap = r_reg.lfsr[3:0];
							r_next.state = S_GAP;
						end
					end
				end
				S_GAP: begin
					if (r_reg.gap == 4'h0) begin
						r_next.state = S_IDLE;
					end else begin
						r_next.gap = r_reg.gap - 4'h1;
					end
				end
			endcase
		end
		if (REG_WR_IN) begin
			unique case (REG_ADDR_IN)
				`EPG_OFF_SCRATCH: r_next.scratch = REG_WDATA_IN;
				`EPG_OFF_SIZE: r_next.size = REG_WDATA_IN[29:0];
				`EPG_OFF_COUNT: r_next.count = REG_WDATA_IN;
				`EPG_OFF_CTRL: begin
					r_next.ctrl = REG_WDATA_IN[7:0];
					if (REG_WDATA_IN[`EPG_CTRL_DIS]) begin
						r_next.sent = 32'h0000_0000;
					end
				end
				`EPG_OFF_DAL: r_next.dal = REG_WDATA_IN;
				`EPG_OFF_DAH: r_next.dah = REG_WDATA_IN[15:0];
				`EPG_OFF_SAL: r_next.sal = REG_WDATA_IN;
				`EPG_OFF_SAH: r_next.sah = REG_WDATA_IN[15:0];
				default: r_next.scratch = r_reg.scratch;
			endcase
		end
		if (REG_RD_IN) begin
			r_next.rvalid = 1'b1;
			r_next.rdata = reg_read(r_reg, REG_ADDR_IN, LOOPBACK_IN);
		end
	end

	// state register
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			r_reg <= RST_VAL;
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from flip-flops
	assign REG_RDATA_OUT = r_reg.rdata;
	assign REG_RDVALID_OUT = r_reg.rvalid;
	assign TX_DATA_OUT = r_reg.data;
	assign TX_VALID_OUT = r_reg.valid;
	assign TX_SOP_OUT = r_reg.sop;
	assign TX_EOP_OUT = r_reg.eop;
	assign TX_EMPTY_OUT = r_reg.empty;

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_N_IN);

	sequence s_scratch_wr;
		REG_WR_IN && REG_ADDR_IN == `EPG_OFF_SCRATCH;
	endsequence
	sequence s_scratch_rd;
		REG_RD_IN && !REG_WR_IN && REG_ADDR_IN == `EPG_OFF_SCRATCH;
	endsequence

	a_scratch_readback: assert property (
		s_scratch_wr ##1 !REG_WR_IN ##1 s_scratch_rd |=>
		REG_RDATA_OUT == $past(REG_WDATA_IN, 3))
		else $error("scratch readback mismatch");
	a_id_word: assert property (
		REG_RD_IN && REG_ADDR_IN == `EPG_OFF_ID |=> REG_RDVALID_OUT &&
		REG_RDATA_OUT == CLIENT_ID)
		else $error("id word wrong");
	a_eop_empty: assert property (
		TX_VALID_OUT && TX_EOP_OUT |-> TX_EMPTY_OUT ==
		((r_reg.size[`EPG_SIZE_MSB:0] < `EPG_MIN_LEN) ? 3'h0 : 3'h0 - r_reg.size[2:0]))
		else $error("last beat empty count wrong");
	a_count_halt: assert property (
		TX_VALID_OUT && TX_SOP_OUT && !$past(TX_SOP_OUT && TX_VALID_OUT) |->
		!$past(r_reg.ctrl[`EPG_CTRL_CSTOP] && r_reg.sent >= r_reg.count))
		else $error("frame started after count reached");
	a_disable_start: assert property (
		$rose(TX_VALID_OUT && TX_SOP_OUT) |-> !$past(r_reg.ctrl[`EPG_CTRL_DIS]))
		else $error("frame started while disabled");
	a_pattern_mode: assert property (
		$rose(TX_VALID_OUT && TX_SOP_OUT) |->
		$past(r_reg.ctrl[`EPG_CTRL_PAT_HI:`EPG_CTRL_PAT_LO]) == `EPG_PAT_FIXED)
		else $error("frame started in reserved pattern");
	a_gap_select: assert property (
		TX_VALID_OUT && TX_EOP_OUT && TX_READY_IN |->
		(r_reg.ctrl[`EPG_CTRL_B2B] ? r_reg.state == S_IDLE : r_reg.state == S_GAP))
		else $error("gap state wrong after frame");
	a_header_order: assert property (
		TX_VALID_OUT && TX_SOP_OUT |-> TX_DATA_OUT[63:16] == {r_reg.dah, r_reg.dal} ||
		$past(REG_WR_IN))
		else $error("destination not first");
	a_stall_hold: assert property (
		TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT) &&
		$stable(TX_SOP_OUT) && $stable(TX_EOP_OUT))
		else $error("beat changed while stalled");
	a_high_zero: assert property (
		REG_RD_IN && (REG_ADDR_IN == `EPG_OFF_DAH || REG_ADDR_IN == `EPG_OFF_SAH) |=>
		REG_RDATA_OUT[31:16] == 16'h0000)
		else $error("upper bits not zero");
	a_loopback_bit: assert property (
		REG_RD_IN && REG_ADDR_IN == `EPG_OFF_CTRL |=>
		REG_RDATA_OUT[`EPG_CTRL_LPBK] == $past(LOOPBACK_IN))
		else $error("loopback bit wrong");
endmodule
`default_nettype wire
